// ### core/crs_pkg.sv
package crs_pkg;

  // clock and delay timing
  localparam int CLK_MHZ = 250;
  localparam int DELAY_TIME_MS = 18;
  localparam int TB_TICK_NS = 1000;
  localparam int TB_DIV = TB_TICK_NS * CLK_MHZ / 1000;
  localparam int DELAY_TICKS = DELAY_TIME_MS * 1000000 / TB_TICK_NS;
  localparam int DELAY_W = 16;
  localparam int TB_W = 8;
  localparam int CLOCK_OUT_DIV = 4;

  // register indices, byte address is index times four
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_PROG_CTR_LOW = 6'h02;
  localparam logic [5:0] IDX_CORE_STATUS = 6'h03;
  localparam logic [5:0] IDX_INDIRECT_POINTER = 6'h04;
  localparam logic [5:0] IDX_PORT_DIRECTION = 6'h08;
  localparam logic [5:0] IDX_OPTION = 6'h09;
  localparam logic [5:0] IDX_CONFIG = 6'h0A;
  localparam logic [5:0] IDX_CAUSE = 6'h0B;
  localparam logic [5:0] IDX_SCRATCH = 6'h0C;

  // reset values and field positions
  localparam logic [7:0] PROG_CTR_LOW_RST = 8'hFF;
  localparam logic [7:0] CORE_STATUS_POR = 8'h18;
  localparam logic [7:0] PORT_DIRECTION_RST = 8'hFF;
  localparam logic [5:0] OPTION_RST = 6'h3F;
  localparam int INDIRECT_MSB = 7;
  localparam int CONFIG_RC_BIT = 0;
  localparam logic CONFIG_RC_RST = 1'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CRS_CAUSE_POR,
    CRS_CAUSE_CLEAR_RUN,
    CRS_CAUSE_CLEAR_WAKE,
    CRS_CAUSE_WATCHDOG_RUN,
    CRS_CAUSE_WATCHDOG_WAKE
  } crs_cause_type;

  typedef enum logic [1:0] {
    CRS_ST_HOLD,
    CRS_ST_RUN,
    CRS_ST_SLEEP
  } crs_state_type;

  typedef struct packed {
    logic [2:0] upper;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [2:0] lower;
  } crs_status_type;

endpackage

// ### core/crs_sync2.sv
module crs_sync2 (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // level in and out
  input wire logic din,
  output logic dout
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule

// ### core/crs_delay_timer.sv
module crs_delay_timer #(
  parameter int TERM_TICKS = crs_pkg::DELAY_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic count_en,
  input wire logic restart,
  // result
  output logic expired
);

  logic [crs_pkg::TB_W-1:0] tb_q;
  logic [crs_pkg::DELAY_W-1:0] cnt_q;
  logic tick;
  logic last;

  // free-running timebase, never gated by the delay logic
  assign tick = (tb_q == crs_pkg::TB_W'(crs_pkg::TB_DIV - 1));
  assign last = (cnt_q == crs_pkg::DELAY_W'(TERM_TICKS - 1));
  assign expired = count_en & tick & last;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_q <= '0;
    end else if (tick) begin
      tb_q <= '0;
    end else begin
      tb_q <= tb_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || restart || !count_en) begin
      cnt_q <= '0;
    end else if (tick && !last) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// ### core/crs_reset_seq.sv
// Operation
// RULE1: five reset conditions are told apart
// RULE2: unaffected registers keep value, never reset
// RULE3: wake-up from sleep does full reset
// RULE4: defined registers reload on every reset
// RULE5: timeout and powerdown flags at status 4:3
// RULE6: program counter low ones; status 0001 1xxx
// RULE7: master clear run: clear 7:5, keep rest
// RULE8: master clear wake: 000, timeout 1, powerdown 0
// RULE9: watchdog run: clear 7:5 and TO
// RULE10: watchdog wake: clear 7:5, TO and PD
// RULE11: clear-watchdog sets timeout and powerdown flags
// RULE12: direction, option, pointer MSB to ones
// RULE13: power-up sets latch, clears delay timer
// RULE14: delay timer idle while master clear low
// RULE15: delay expiry releases chip reset
// RULE16: driver holds master clear low until supply good
// RULE17: no internal reset on supply fall
// RULE18: driver holds master clear within operating range
// RULE19: RC mode drives clock divided by four
// RULE20: watchdog time-out restarts delay timer
// RULE21: delay timer on own free-running timebase
// RULE22: master clear synchronised before use
//
// The AXI4-Lite interface to the registers was left to the implementer.
module crs_reset_seq #(
  parameter int DELAY_TICKS = crs_pkg::DELAY_TICKS
) (
  // clock and power-up reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic master_clear_n,
  output logic divided_clock_out_pin,
  // core events, same clock, one-cycle pulses
  input wire logic watchdog_timeout,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  // core-facing reset and register values
  output logic chip_reset,
  output logic [7:0] prog_ctr_low,
  output logic [7:0] core_status,
  output logic [7:0] indirect_pointer,
  output logic [7:0] port_direction,
  output logic [5:0] option_bits,
  // axi4-lite write address
  input wire logic [crs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [crs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  crs_pkg::crs_state_type state_q;
  crs_pkg::crs_state_type state_d;
  crs_pkg::crs_cause_type cause_q;
  crs_pkg::crs_cause_type cause_d;
  crs_pkg::crs_status_type status_q;
  crs_pkg::crs_status_type status_d;
  logic [7:0] prog_ctr_low_q;
  logic indirect_msb_q;
  logic [6:0] indirect_low_q;
  logic [7:0] port_direction_q;
  logic [5:0] option_q;
  logic rc_mode_q;
  logic [7:0] scratch_q;
  logic [1:0] div_q;
  logic clk_out_q;
  logic clear_sync;
  logic delay_expired;
  logic delay_count_en;
  logic is_hold;
  logic is_run;
  logic is_sleep;
  logic clear_evt;
  logic watchdog_evt;
  logic rst_evt;

  // master clear pin through two flops
  crs_sync2 u_clear_sync ( // RULE22
    .aclk(aclk),
    .aresetn(aresetn),
    .din(master_clear_n),
    .dout(clear_sync)
  );

  assign is_hold = (state_q == crs_pkg::CRS_ST_HOLD);
  assign is_run = (state_q == crs_pkg::CRS_ST_RUN);
  assign is_sleep = (state_q == crs_pkg::CRS_ST_SLEEP);
  // supply fall has no input here: only aresetn (power-up) and the pin reset
  assign clear_evt = !clear_sync && !is_hold; // RULE17
  assign watchdog_evt = watchdog_timeout;
  assign rst_evt = clear_evt || watchdog_evt; // RULE1

  // delay counts only while held and master clear seen high
  assign delay_count_en = is_hold && clear_sync; // RULE14

  crs_delay_timer #(
    .TERM_TICKS(DELAY_TICKS)
  ) u_delay ( // RULE21
    .aclk(aclk),
    .aresetn(aresetn), // RULE13
    .count_en(delay_count_en),
    .restart(watchdog_evt), // RULE20
    .expired(delay_expired)
  );

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      crs_pkg::CRS_ST_HOLD: begin
        if (delay_expired && !watchdog_evt) begin
          state_d = crs_pkg::CRS_ST_RUN; // RULE15
        end
      end
      crs_pkg::CRS_ST_RUN: begin
        if (rst_evt) begin
          state_d = crs_pkg::CRS_ST_HOLD;
        end else if (sleep_instr) begin
          state_d = crs_pkg::CRS_ST_SLEEP;
        end
      end
      crs_pkg::CRS_ST_SLEEP: begin
        if (rst_evt) begin
          state_d = crs_pkg::CRS_ST_HOLD; // RULE3
        end
      end
      default: begin
        state_d = crs_pkg::CRS_ST_HOLD;
      end
    endcase
  end

  // cause of the latest reset
  always_comb begin
    cause_d = cause_q;
    if (watchdog_evt) begin
      cause_d = is_sleep ? crs_pkg::CRS_CAUSE_WATCHDOG_WAKE : crs_pkg::CRS_CAUSE_WATCHDOG_RUN; // RULE1
    end else if (clear_evt) begin
      cause_d = is_sleep ? crs_pkg::CRS_CAUSE_CLEAR_WAKE : crs_pkg::CRS_CAUSE_CLEAR_RUN; // RULE1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= crs_pkg::CRS_ST_HOLD; // RULE13
      cause_q <= crs_pkg::CRS_CAUSE_POR;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  assign chip_reset = is_hold;

  // bus decode
  logic wr_fire;
  logic rd_fire;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_status;
  logic wr_ptr;
  logic wr_dir;
  logic wr_opt;
  logic wr_cfg;
  logic wr_scr;
  logic wr_prog;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_fire = s_axi_awready;
  assign wr_idx = s_axi_awaddr[7:2];
  // lane 0 holds the whole 8-bit register
  assign wbyte = s_axi_wdata[7:0];
  assign wr_prog = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_PROG_CTR_LOW);
  assign wr_status = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_CORE_STATUS);
  assign wr_ptr = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_INDIRECT_POINTER);
  assign wr_dir = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_PORT_DIRECTION);
  assign wr_opt = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_OPTION);
  assign wr_cfg = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_CONFIG);
  assign wr_scr = wr_fire && s_axi_wstrb[0] && (wr_idx == crs_pkg::IDX_SCRATCH);
  assign wr_hit = (wr_idx == crs_pkg::IDX_PROG_CTR_LOW) || (wr_idx == crs_pkg::IDX_CORE_STATUS) ||
                  (wr_idx == crs_pkg::IDX_INDIRECT_POINTER) || (wr_idx == crs_pkg::IDX_PORT_DIRECTION) ||
                  (wr_idx == crs_pkg::IDX_OPTION) || (wr_idx == crs_pkg::IDX_CONFIG) ||
                  (wr_idx == crs_pkg::IDX_CAUSE) || (wr_idx == crs_pkg::IDX_SCRATCH);

  // status: flags are hardware-owned, reset events win over everything
  always_comb begin
    status_d = status_q;
    if (wr_status) begin
      status_d.upper = wbyte[7:5];
      status_d.lower = wbyte[2:0];
    end
    if (clear_watchdog_instr && is_run) begin
      status_d.timeout_flag_n = 1'b1; // RULE11
      status_d.powerdown_flag_n = 1'b1; // RULE11
    end
    if (sleep_instr && is_run) begin
      status_d.timeout_flag_n = 1'b1;
      status_d.powerdown_flag_n = 1'b0;
    end
    if (rst_evt) begin
      status_d.upper = 3'h0; // RULE7
      status_d.lower = status_q.lower;
      if (watchdog_evt) begin
        status_d.timeout_flag_n = 1'b0; // RULE9
        status_d.powerdown_flag_n = is_sleep ? 1'b0 : status_q.powerdown_flag_n; // RULE10
      end else if (is_sleep) begin
        status_d.timeout_flag_n = 1'b1; // RULE8
        status_d.powerdown_flag_n = 1'b0; // RULE8
      end else begin
        status_d.timeout_flag_n = status_q.timeout_flag_n; // RULE7
        status_d.powerdown_flag_n = status_q.powerdown_flag_n;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= crs_pkg::CORE_STATUS_POR; // RULE6
    end else begin
      status_q <= status_d; // RULE5
    end
  end

  // defined-state registers
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_evt) begin
      prog_ctr_low_q <= crs_pkg::PROG_CTR_LOW_RST; // RULE6
      indirect_msb_q <= 1'b1; // RULE12
      port_direction_q <= crs_pkg::PORT_DIRECTION_RST; // RULE12
      option_q <= crs_pkg::OPTION_RST; // RULE4
    end else begin
      if (wr_prog) begin
        prog_ctr_low_q <= wbyte;
      end
      if (wr_ptr) begin
        indirect_msb_q <= wbyte[crs_pkg::INDIRECT_MSB];
      end
      if (wr_dir) begin
        port_direction_q <= wbyte;
      end
      if (wr_opt) begin
        option_q <= wbyte[5:0];
      end
    end
  end

  // unaffected registers: no reset term at all
  always_ff @(posedge aclk) begin
    if (wr_ptr) begin
      indirect_low_q <= wbyte[6:0]; // RULE2
    end
    if (wr_scr) begin
      scratch_q <= wbyte; // RULE2
    end
  end

  // configuration survives core resets, cleared only on power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_mode_q <= crs_pkg::CONFIG_RC_RST;
    end else if (wr_cfg) begin
      rc_mode_q <= wbyte[crs_pkg::CONFIG_RC_BIT];
    end
  end

  // clock out: aclk stands for the oscillator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 2'h0;
      clk_out_q <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      clk_out_q <= rc_mode_q && (div_q < 2'(crs_pkg::CLOCK_OUT_DIV / 2)); // RULE19
    end
  end

  assign divided_clock_out_pin = clk_out_q;

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= crs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[7:2];
  assign rd_hit = (rd_idx == crs_pkg::IDX_PROG_CTR_LOW) || (rd_idx == crs_pkg::IDX_CORE_STATUS) ||
                  (rd_idx == crs_pkg::IDX_INDIRECT_POINTER) || (rd_idx == crs_pkg::IDX_PORT_DIRECTION) ||
                  (rd_idx == crs_pkg::IDX_OPTION) || (rd_idx == crs_pkg::IDX_CONFIG) ||
                  (rd_idx == crs_pkg::IDX_CAUSE) || (rd_idx == crs_pkg::IDX_SCRATCH);
  assign rd_byte = (rd_idx == crs_pkg::IDX_PROG_CTR_LOW) ? prog_ctr_low_q :
                   (rd_idx == crs_pkg::IDX_CORE_STATUS) ? status_q :
                   (rd_idx == crs_pkg::IDX_INDIRECT_POINTER) ? {indirect_msb_q, indirect_low_q} :
                   (rd_idx == crs_pkg::IDX_PORT_DIRECTION) ? port_direction_q :
                   (rd_idx == crs_pkg::IDX_OPTION) ? {2'h0, option_q} :
                   (rd_idx == crs_pkg::IDX_CONFIG) ? {7'h00, rc_mode_q} :
                   (rd_idx == crs_pkg::IDX_CAUSE) ? {3'h0, cause_q, is_sleep, is_hold} :
                   (rd_idx == crs_pkg::IDX_SCRATCH) ? scratch_q : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= crs_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? crs_pkg::RESP_OKAY : crs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // core-facing copies
  assign prog_ctr_low = prog_ctr_low_q;
  assign core_status = status_q;
  assign indirect_pointer = {indirect_msb_q, indirect_low_q};
  assign port_direction = port_direction_q;
  assign option_bits = option_q;

endmodule

// ### testbench/crs_reset_seq_asserts.sv
module crs_reset_seq_asserts #(
  parameter int DELAY_TICKS = crs_pkg::DELAY_TICKS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and events
  input wire logic master_clear_n,
  input wire logic divided_clock_out_pin,
  input wire logic watchdog_timeout,
  input wire logic sleep_instr,
  input wire logic clear_watchdog_instr,
  // core side
  input wire logic chip_reset,
  input wire logic [7:0] prog_ctr_low,
  input wire logic [7:0] core_status,
  input wire logic [7:0] indirect_pointer,
  input wire logic [7:0] port_direction,
  input wire logic [5:0] option_bits
);
  localparam int LO = (DELAY_TICKS - 1) * crs_pkg::TB_DIV;
  localparam int HI = DELAY_TICKS * crs_pkg::TB_DIV + 8;
  logic sleeping_q;
  int cnt_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // sleep tracked from the instruction, left on any chip reset
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_reset) sleeping_q <= 1'b0;
    else if (sleep_instr) sleeping_q <= 1'b1;
  end

  // cycles of hold since the last restart cause
  always_ff @(posedge aclk) begin
    if (!aresetn || !chip_reset || !master_clear_n || watchdog_timeout) cnt_q <= 0;
    else cnt_q <= cnt_q + 1;
  end

  // after a fall: low, high, high, low; a short first pulse on enable is not a fall
  sequence s_half_wave;
    !divided_clock_out_pin ##1 divided_clock_out_pin ##1 divided_clock_out_pin ##1 !divided_clock_out_pin;
  endsequence

  sequence s_pin_quiet;
    master_clear_n && $past(master_clear_n) && $past(master_clear_n, 2) && $past(master_clear_n, 3);
  endsequence

  a_watchdog_reload: assert property (watchdog_timeout |=> chip_reset && prog_ctr_low == 8'hFF &&
    port_direction == 8'hFF && option_bits == 6'h3F && indirect_pointer[7])
    else $error("watchdog reset did not reload registers");
  a_watchdog_flag: assert property (watchdog_timeout |=> core_status[7:5] == 3'h0 && !core_status[4])
    else $error("watchdog reset did not clear timeout flag");
  a_watchdog_wake: assert property (watchdog_timeout && sleeping_q |=> core_status[7:3] == 5'h00)
    else $error("watchdog wake status wrong");
  a_master_clear_run: assert property ($rose(chip_reset) && !$past(watchdog_timeout) && !$past(sleeping_q)
    |-> core_status[7:5] == 3'h0 && core_status[4:3] == $past(core_status[4:3]))
    else $error("master clear run status wrong");
  a_master_clear_wake: assert property ($rose(chip_reset) && !$past(watchdog_timeout) && $past(sleeping_q)
    |-> core_status[7:3] == 5'h02)
    else $error("master clear wake status wrong");
  a_watchdog_clear_flags: assert property (s_pin_quiet and (clear_watchdog_instr && !chip_reset &&
    !sleep_instr && !sleeping_q && !watchdog_timeout) |=> core_status[4:3] == 2'h3)
    else $error("clear watchdog did not set flags");
  a_release_wait: assert property ($fell(chip_reset) |-> cnt_q >= LO)
    else $error("chip reset released too early");
  a_hold_bound: assert property (chip_reset && master_clear_n |-> cnt_q <= HI)
    else $error("chip reset held too long");
  a_clock_out_div: assert property ($fell(divided_clock_out_pin) |=> s_half_wave)
    else $error("clock out not divided by four");
endmodule

bind crs_reset_seq crs_reset_seq_asserts #(.DELAY_TICKS(DELAY_TICKS)) u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .master_clear_n(master_clear_n),
  .divided_clock_out_pin(divided_clock_out_pin),
  .watchdog_timeout(watchdog_timeout),
  .sleep_instr(sleep_instr),
  .clear_watchdog_instr(clear_watchdog_instr),
  .chip_reset(chip_reset),
  .prog_ctr_low(prog_ctr_low),
  .core_status(core_status),
  .indirect_pointer(indirect_pointer),
  .port_direction(port_direction),
  .option_bits(option_bits)
);

// ### testbench/crs_master_clear_n_model.sv
module crs_master_clear_model (
  // clock
  input wire logic aclk,
  // supply state and reset request
  input wire logic supply_ok,
  input wire logic pulse_req,
  // pin
  output logic master_clear_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // held low until supply is good, or while a reset is asked
  always @(posedge aclk) master_clear_n <= supply_ok && !pulse_req;
endmodule

// ### testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DT = 4;
  logic aclk, aresetn, supply_ok, clear_req, master_clear_n, divided_clock_out_pin;
  logic watchdog_timeout, sleep_instr, clear_watchdog_instr, chip_reset;
  logic [2:0] ev;
  logic [7:0] prog_ctr_low, core_status, indirect_pointer, port_direction, s_axi_awaddr, s_axi_araddr;
  logic [5:0] option_bits;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s;
  int err_count = 0;
  int checked = 0;
  int wn;

  assign {watchdog_timeout, sleep_instr, clear_watchdog_instr} = ev;

  crs_reset_seq #(.DELAY_TICKS(DT)) uut (.aclk, .aresetn, .master_clear_n, .divided_clock_out_pin,
    .watchdog_timeout, .sleep_instr, .clear_watchdog_instr, .chip_reset, .prog_ctr_low, .core_status,
    .indirect_pointer, .port_direction, .option_bits, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  crs_master_clear_model drv (.aclk, .supply_ok, .pulse_req(clear_req), .master_clear_n);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    test_done();
  end

  task test_done;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !dd) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one-cycle core event, result settled on return
  task evp(input logic [2:0] k);
    @(posedge aclk);
    ev <= k;
    @(posedge aclk);
    ev <= 3'h0;
    #1;
  endtask

  task clear_pulse;
    @(posedge aclk);
    clear_req <= 1'b1;
    repeat (8) @(posedge aclk);
    clear_req <= 1'b0;
    #1;
  endtask

  task wait_run;
    wn = 0;
    while (chip_reset === 1'b1 && wn < 3000) begin
      @(posedge aclk);
      wn++;
    end
    #1;
    chk({7'h00, chip_reset}, 8'h00);
    $display("test step done at %0t", $time);
  endtask

  initial begin
    aresetn = 1'b0;
    supply_ok = 1'b0;
    clear_req = 1'b0;
    ev = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk(core_status, 8'h18);
    chk(prog_ctr_low, 8'hFF);
    chk({indirect_pointer[7], 1'h0, option_bits}, 8'hBF);
    repeat (1500) @(posedge aclk);
    chk({7'h00, chip_reset}, 8'h01);
    supply_ok <= 1'b1;
    wait_run();
    wr(8'h30, 8'h5A);
    wr(8'h08, 8'h00);
    wr(8'h10, 8'h35);
    wr(8'h20, 8'h00);
    wr(8'h24, 8'h00);
    wr(8'h0C, 8'hE7);
    chk(core_status, 8'hFF);
    chk(prog_ctr_low, 8'h00);
    chk(indirect_pointer, 8'h35);
    chk({port_direction[7:6], option_bits}, 8'h00);
    clear_pulse();
    chk(core_status, 8'h1F);
    chk(prog_ctr_low, 8'hFF);
    chk(indirect_pointer, 8'hB5);
    chk({port_direction[7:6], option_bits}, 8'hFF);
    rdr(8'h30);
    chk(rd[7:0], 8'h5A);
    rdr(8'h2C);
    chk(rd[7:0], 8'h05);
    wait_run();
    wr(8'h0C, 8'hE7);
    evp(3'h4);
    chk(core_status, 8'h0F);
    repeat (600) @(posedge aclk);
    evp(3'h4);
    wait_run();
    chk({7'h00, wn >= (DT - 1) * crs_pkg::TB_DIV}, 8'h01);
    wr(8'h0C, 8'hE7);
    evp(3'h2);
    chk(core_status, 8'hF7);
    evp(3'h4);
    chk({core_status[7:1], chip_reset}, 8'h07);
    rdr(8'h2C);
    chk(rd[7:0], 8'h11);
    wait_run();
    wr(8'h0C, 8'hE7);
    evp(3'h2);
    clear_pulse();
    chk({core_status[7:1], chip_reset}, 8'h17);
    rdr(8'h2C);
    chk(rd[7:0], 8'h09);
    wait_run();
    evp(3'h1);
    chk(core_status, 8'h1F);
    rdr(8'h0C);
    chk(rd[7:0], 8'h1F);
    wr(8'h28, 8'h01);
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      #1;
      s[i] = divided_clock_out_pin;
    end
    chk(s ^ {s[5:0], s[7:6]}, 8'hFF);
    rdr(8'hFC);
    chk({6'h00, rsp}, {6'h00, crs_pkg::RESP_SLVERR});
    wr(8'hFC, 8'h00);
    chk({6'h00, rsp}, {6'h00, crs_pkg::RESP_SLVERR});
    test_done();
  end
endmodule
